// ===== core/rsc_config_top.sv
// Top of the receiver sensitivity configuration register bank
//
// Summary of operation
// - An 8-bit readable and writable sensitivity register sits at 0x25.
// - After reset the sensitivity field is loaded from the sensed strap.
// - Strap low, mid and high load 0x00, 0x33 and 0x66.
// - Software may write any value 0x00 to 0xff, 0xff being the highest.
// - Boost strap short, lower, higher resistor and open give levels 0-3.
// - Sensitivity strap a only is low, none is mid, b only is high.
// - In serial mode, bit 0 at 0x03 selects configuration or normal mode.
`timescale 1ns/1ps
module rsc_config_top
    import rsc_pkg::*;
#(
    parameter int         SETTLE_CYC  = RSC_STRAP_SETTLE_CYC,
    parameter logic [6:0] CFG_RSV_RST = 7'h00
)
(
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic       sens_above_low_in,
    input  wire logic       sens_above_high_in,
    input  wire logic [2:0] boost_thermo_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic [7:0]      rx_sens_level_out,
    output logic [1:0]      boost_level_out,
    output logic            cfg_mode_out,
    output logic            serial_mode_out,
    output logic            strap_done_out
);

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX,
                              ST_TX_ACK} rsc_bus_state_t;

    rsc_strap_t     strap;
    logic [1:0]     scl_sync;
    logic [1:0]     sda_sync;
    logic           scl_prev;
    logic           sda_prev;
    logic           scl_rise;
    logic           scl_fall;
    logic           bus_start;
    logic           bus_stop;
    rsc_bus_state_t state;
    logic [7:0]     shreg;
    logic [2:0]     bit_cnt;
    logic           byte_done;
    logic           first_byte;
    logic           have_ptr;
    logic           is_read;
    logic           acked;
    logic [7:0]     reg_ptr;
    logic [7:0]     rd_data;
    rsc_wr_req_t    wr_req;
    logic [7:0]     rx_sensitivity_level;
    logic [7:0]     config_reg;

    rsc_strap_sampler #(
        .SETTLE_CYC         (SETTLE_CYC)
    ) u_strap (
        .clk_sys_in         (clk_sys_in),
        .rst_in             (rst_in),
        .sens_above_low_in  (sens_above_low_in),
        .sens_above_high_in (sens_above_high_in),
        .boost_thermo_in    (boost_thermo_in),
        .strap_out          (strap)
    );

    // Bus pin synchronisers and edge history
    always_ff @(posedge clk_sys_in)
    begin
        scl_sync <= {scl_sync[0], scl_in};
        sda_sync <= {sda_sync[0], sda_in};
        // History resets to idle high so no false edge follows reset
        {scl_prev, sda_prev} <= rst_in ? 2'h3 : {scl_sync[1], sda_sync[1]};
    end

    // Bus edges and start/stop conditions
    assign scl_rise  = scl_sync[1] & ~scl_prev;
    assign scl_fall  = ~scl_sync[1] & scl_prev;
    assign bus_start = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
    assign bus_stop  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

    // Read data mux; unmapped offsets read as zero
    always_comb
    begin
        case (reg_ptr)
            RSC_OFS_RX_SENS: rd_data = rx_sensitivity_level;
            RSC_OFS_CONFIG:  rd_data = config_reg;
            default:         rd_data = RSC_UNMAPPED_RD;
        endcase
    end

    // Serial target engine; runs only in serial mode
    always_ff @(posedge clk_sys_in)
    begin
        wr_req.wr <= 1'b0;
        if (rst_in || !serial_mode_out)
        begin
            state      <= ST_IDLE;
            shreg      <= 8'h00;
            bit_cnt    <= 3'h0;
            byte_done  <= 1'b0;
            first_byte <= 1'b0;
            have_ptr   <= 1'b0;
            is_read    <= 1'b0;
            acked      <= 1'b0;
            reg_ptr    <= 8'h00;
            sda_oe_out <= 1'b0;
            wr_req     <= '0;
        end
        else if (bus_start)
        begin
            state      <= ST_RX;
            bit_cnt    <= 3'h0;
            byte_done  <= 1'b0;
            first_byte <= 1'b1;
            have_ptr   <= 1'b0;
            sda_oe_out <= 1'b0;
        end
        else if (bus_stop)
        begin
            state      <= ST_IDLE;
            sda_oe_out <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shreg     <= {shreg[6:0], sda_sync[1]};
                        bit_cnt   <= bit_cnt + 3'h1;
                        byte_done <= (bit_cnt == 3'h7);
                    end
                    else if (scl_fall && byte_done)
                    begin
                        byte_done <= 1'b0;
                        if (first_byte)
                        begin
                            first_byte <= 1'b0;
                            is_read    <= shreg[0];
                            if (shreg[7:1] == RSC_TARGET_ADDR)
                            begin
                                sda_oe_out <= 1'b1;
                                state      <= ST_RX_ACK;
                            end
                            else
                                state <= ST_IDLE;
                        end
                        else if (!have_ptr)
                        begin
                            have_ptr   <= 1'b1;
                            reg_ptr    <= shreg;
                            sda_oe_out <= 1'b1;
                            state      <= ST_RX_ACK;
                        end
                        else
                        begin
                            wr_req.wr   <= 1'b1;
                            wr_req.addr <= reg_ptr;
                            wr_req.data <= shreg;
                            reg_ptr     <= reg_ptr + 8'h01;
                            sda_oe_out  <= 1'b1;
                            state       <= ST_RX_ACK;
                        end
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (is_read)
                        begin
                            shreg      <= rd_data;
                            sda_oe_out <= ~rd_data[7];
                            reg_ptr    <= reg_ptr + 8'h01;
                            bit_cnt    <= 3'h0;
                            state      <= ST_TX;
                        end
                        else
                        begin
                            sda_oe_out <= 1'b0;
                            state      <= ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt == 3'h7)
                        begin
                            sda_oe_out <= 1'b0;
                            state      <= ST_TX_ACK;
                        end
                        else
                        begin
                            shreg      <= {shreg[6:0], 1'b0};
                            sda_oe_out <= ~shreg[6];
                            bit_cnt    <= bit_cnt + 3'h1;
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                        acked <= ~sda_sync[1];
                    else if (scl_fall)
                    begin
                        if (acked)
                        begin
                            shreg      <= rd_data;
                            sda_oe_out <= ~rd_data[7];
                            reg_ptr    <= reg_ptr + 8'h01;
                            bit_cnt    <= 3'h0;
                            state      <= ST_TX;
                        end
                        else
                            state <= ST_IDLE;
                    end
                end
                default:
                    sda_oe_out <= 1'b0;
            endcase
        end
    end

    // Open-drain data pin only ever pulls low
    assign sda_out = 1'b0;

    // Sensitivity register: strap load once, then software owns it
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            rx_sensitivity_level <= RSC_SENS_RST;
            rx_sens_level_out    <= RSC_SENS_RST;
        end
        else
        begin
            if (strap.done && !strap_done_out)
                case (strap.sens)
                    RSC_LVL_HIGH: rx_sensitivity_level <= RSC_SENS_HIGH;
                    RSC_LVL_MID:  rx_sensitivity_level <= RSC_SENS_MID;
                    default:      rx_sensitivity_level <= RSC_SENS_LOW;
                endcase
            // Any 8-bit value accepted, later than strap load
            if (wr_req.wr && wr_req.addr == RSC_OFS_RX_SENS)
                rx_sensitivity_level <= wr_req.data;
            // Live copy runs one cycle behind the register
            rx_sens_level_out <= rx_sensitivity_level;
        end
    end

    // Configuration register and the mode bit it selects
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            config_reg   <= {CFG_RSV_RST, RSC_CFG_ACTIVE_RST};
            cfg_mode_out <= 1'b0;
        end
        else
        begin
            if (wr_req.wr && wr_req.addr == RSC_OFS_CONFIG)
                config_reg <= wr_req.data;
            cfg_mode_out <= serial_mode_out &
                            config_reg[RSC_CFG_ACTIVE_BIT];
        end
    end

    // Mode capture: serial mode when both bus lines high at sampling
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            serial_mode_out <= 1'b0;
            strap_done_out  <= 1'b0;
            boost_level_out <= 2'h0;
        end
        else if (strap.done && !strap_done_out)
        begin
            serial_mode_out <= scl_sync[1] & sda_sync[1];
            strap_done_out  <= 1'b1;
            boost_level_out <= strap.boost;
        end
    end

endmodule

// ===== core/rsc_pkg.sv
// Package of constants and types for the sensitivity strap configuration
package rsc_pkg;

    // Register offsets
    localparam logic [7:0] RSC_OFS_CONFIG   = 8'h03;
    localparam logic [7:0] RSC_OFS_RX_SENS  = 8'h25;

    // Configuration register field positions and reset values
    localparam int         RSC_CFG_ACTIVE_BIT = 0;
    localparam logic       RSC_CFG_ACTIVE_RST = 1'h1;

    // Sensitivity codes loaded from the strap, and the highest code
    localparam logic [7:0] RSC_SENS_LOW    = 8'h00;
    localparam logic [7:0] RSC_SENS_MID    = 8'h33;
    localparam logic [7:0] RSC_SENS_HIGH   = 8'h66;
    localparam logic [7:0] RSC_SENS_MAX    = 8'hff;
    // Held until the strap has been sampled
    localparam logic [7:0] RSC_SENS_RST    = 8'h00;

    // Value shown on an unmapped read
    localparam logic [7:0] RSC_UNMAPPED_RD = 8'h00;

    // Strap settling time before sampling
    localparam int         RSC_CLK_MHZ        = 250;
    localparam int         RSC_STRAP_SETTLE_NS = 100;
    localparam int         RSC_STRAP_SETTLE_CYC =
        (RSC_STRAP_SETTLE_NS * RSC_CLK_MHZ + 999) / 1000;

    // Serial target address, arbitrary value
    localparam logic [6:0] RSC_TARGET_ADDR = 7'h2c;

    // Sensed levels of the tri-level sensitivity strap
    typedef enum logic [1:0] {
        RSC_LVL_LOW,
        RSC_LVL_MID,
        RSC_LVL_HIGH
    } rsc_sens_lvl_t;

    // Register write request from the serial engine
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } rsc_wr_req_t;

    // Result of the startup strap sampling
    typedef struct packed {
        logic          done;
        rsc_sens_lvl_t sens;
        logic [1:0]    boost;
    } rsc_strap_t;

endpackage

// ===== core/rsc_strap_sampler.sv
// Strap synchroniser, settle timer and level decoder
`timescale 1ns/1ps
module rsc_strap_sampler
    import rsc_pkg::*;
#(
    parameter int SETTLE_CYC = RSC_STRAP_SETTLE_CYC
)
(
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic       sens_above_low_in,
    input  wire logic       sens_above_high_in,
    input  wire logic [2:0] boost_thermo_in,
    output rsc_strap_t      strap_out
);

    // Refuse settle counts that the 16-bit timer cannot hold
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
    begin
        $error("rsc_strap_sampler: SETTLE_CYC out of range");
    end

    logic [4:0]  sync_a;
    logic [4:0]  sync_b;
    logic [15:0] settle_cnt;
    rsc_sens_lvl_t next_sens;
    logic [1:0]  next_boost;

    // Two-flop synchronisers for the strap comparators
    always_ff @(posedge clk_sys_in)
    begin
        sync_a <= {boost_thermo_in, sens_above_high_in, sens_above_low_in};
        sync_b <= sync_a;
    end

    // Tri-level decode: resistor a pulls low, b pulls high, none is mid
    always_comb
    begin
        if (sync_b[1])
            next_sens = RSC_LVL_HIGH;
        else if (sync_b[0])
            next_sens = RSC_LVL_MID;
        else
            next_sens = RSC_LVL_LOW;
    end

    // Boost strap decode: short, lower, higher resistor, open pin
    always_comb
    begin
        case (sync_b[4:2])
            3'h0:    next_boost = 2'h0;
            3'h1:    next_boost = 2'h1;
            3'h3:    next_boost = 2'h2;
            3'h7:    next_boost = 2'h3;
            default: next_boost = 2'h3;
        endcase
    end

    // Settle timer, then one capture per reset
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            settle_cnt      <= 16'h0000;
            strap_out       <= '0;
        end
        else if (!strap_out.done)
        begin
            if (settle_cnt == 16'(SETTLE_CYC - 1))
            begin
                strap_out.done  <= 1'b1;
                strap_out.sens  <= next_sens;
                strap_out.boost <= next_boost;
            end
            else
                settle_cnt <= settle_cnt + 16'h0001;
        end
    end

endmodule

// ===== tb/rsc_config_assertions.sv
// Port checks for the sensitivity strap configuration bank
`timescale 1ns/1ps
module rsc_config_assertions
    import rsc_pkg::*;
#(
    parameter int SETTLE_CYC = 2
)
(
    input wire logic       clk_sys_in,
    input wire logic       rst_in,
    input wire logic       sens_above_low_in,
    input wire logic       sens_above_high_in,
    input wire logic [2:0] boost_thermo_in,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic [7:0] rx_sens_level_out,
    input wire logic [1:0] boost_level_out,
    input wire logic       cfg_mode_out,
    input wire logic       serial_mode_out,
    input wire logic       strap_done_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // Code expected from the two strap comparators
    function automatic logic [7:0] strap_code(logic lo, logic hi);
        return hi ? RSC_SENS_HIGH : (lo ? RSC_SENS_MID : RSC_SENS_LOW);
    endfunction

    // Strap result reaches the live setting shortly after sampling
    chk_strap_code: assert property (
        $rose(strap_done_out) |-> ##[1:3] rx_sens_level_out ==
        strap_code(sens_above_low_in, sens_above_high_in))
        else $error("strap code not loaded");
    chk_boost_decode: assert property (
        $rose(strap_done_out) |-> ##[0:2]
        boost_level_out == 2'($countones(boost_thermo_in)))
        else $error("boost level misdecoded");
    chk_pre_strap_zero: assert property (
        !strap_done_out |-> rx_sens_level_out == RSC_SENS_RST)
        else $error("level moved before strap sampling");
    chk_done_sticky: assert property (
        strap_done_out |=> strap_done_out)
        else $error("strap done dropped");
    // Without bus activity the live setting holds
    chk_rx_quiet: assert property (
        (strap_done_out && $stable(scl_in)) [*8]
        |=> $stable(rx_sens_level_out))
        else $error("level changed without a write");
    chk_cfg_serial: assert property (
        cfg_mode_out |-> serial_mode_out)
        else $error("config mode outside serial mode");
    chk_cfg_after_rst: assert property (
        $rose(serial_mode_out) |-> ##[0:2] cfg_mode_out)
        else $error("config mode not set after reset");
    chk_mode_sticky: assert property (
        strap_done_out && $past(strap_done_out)
        |-> $stable(serial_mode_out))
        else $error("serial mode changed after sampling");
    chk_sda_open_drain: assert property (
        !sda_out && (!sda_oe_out || serial_mode_out))
        else $error("data line driven wrongly");
    // Target moves the data line only while the bus clock is low
    chk_sda_scl_low: assert property (
        $changed(sda_oe_out) |-> !scl_in)
        else $error("data line moved while clock high");
    chk_reset_clears: assert property (
        $fell(rst_in) |-> !strap_done_out && !sda_oe_out
        && rx_sens_level_out == 8'h00)
        else $error("outputs not cleared by reset");
endmodule

// ===== tb/rsc_board_model.sv
// Board straps, pull-up and open-drain data line
`timescale 1ns/1ps
module rsc_board_model
(
    input  wire logic [1:0] sens_sel_in,
    input  wire logic [1:0] boost_sel_in,
    input  wire logic       master_low_in,
    input  wire logic       target_oe_in,
    output logic            above_low_out,
    output logic            above_high_out,
    output logic [2:0]      thermo_out,
    output logic            sda_wire_out
);
    // Resistor a only reads low, none mid, b only high
    assign above_low_out  = (sens_sel_in != 2'h0);
    assign above_high_out = (sens_sel_in == 2'h2);
    // Short, lower, higher resistor, open: rising thermometer
    assign thermo_out = ~(3'h7 << boost_sel_in);
    // Pull-up unless a party pulls the line low
    assign sda_wire_out = !(master_low_in || target_oe_in);
endmodule

// ===== tb/rx_sensitivity_strap_config_tb_top.sv
// Testbench for the sensitivity strap configuration bank
`timescale 1ns/1ps
module rx_sensitivity_strap_config_tb_top;
    import rsc_pkg::*;
    logic       clk_sys_in = 1'b0;
    logic       rst_in     = 1'b1;
    logic       scl_m      = 1'b1;
    logic       sda_low    = 1'b0;
    logic [1:0] sens_sel   = 2'h0;
    logic [1:0] boost_sel  = 2'h0;
    logic       ab_lo, ab_hi, sda_w, sda_o, sda_oe, cfg, ser, done;
    logic [2:0] thermo;
    logic [7:0] rx_lvl, d, code [3], wv [3];
    logic [1:0] bst;
    logic       k;
    int         error_cnt = 0;
    int         n_checks  = 0;

    // Clock
    initial forever #2 clk_sys_in = ~clk_sys_in;

    rsc_config_top #(.SETTLE_CYC(2)) dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .sens_above_low_in(ab_lo), .sens_above_high_in(ab_hi),
        .boost_thermo_in(thermo), .scl_in(scl_m), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .rx_sens_level_out(rx_lvl),
        .boost_level_out(bst), .cfg_mode_out(cfg),
        .serial_mode_out(ser), .strap_done_out(done));
    rsc_board_model board (
        .sens_sel_in(sens_sel), .boost_sel_in(boost_sel),
        .master_low_in(sda_low), .target_oe_in(sda_oe),
        .above_low_out(ab_lo), .above_high_out(ab_hi),
        .thermo_out(thermo), .sda_wire_out(sda_w));

    task automatic chk(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // One bus bit; data moves only well after the clock falls
    task automatic bit_io(input logic b, output logic r);
        wt(2);
        sda_low = !b;
        wt(8);
        scl_m = 1'b1;
        wt(5);
        r = sda_w;
        wt(5);
        scl_m = 1'b0;
    endtask
    task automatic start_c;
        wt(2);
        sda_low = 1'b0;
        wt(10);
        scl_m = 1'b1;
        wt(10);
        sda_low = 1'b1;
        wt(10);
        scl_m = 1'b0;
    endtask
    task automatic stop_c;
        wt(2);
        sda_low = 1'b1;
        wt(10);
        scl_m = 1'b1;
        wt(10);
        sda_low = 1'b0;
        wt(10);
    endtask
    task automatic byte_tx(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic reg_wr(input logic [7:0] a, v, output logic ack);
        logic x;
        start_c;
        byte_tx({RSC_TARGET_ADDR, 1'b0}, ack);
        byte_tx(a, x);
        byte_tx(v, x);
        stop_c;
    endtask
    // Single-byte read, ended by a refused acknowledge
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        logic x;
        start_c;
        byte_tx({RSC_TARGET_ADDR, 1'b0}, x);
        byte_tx(a, x);
        start_c;
        byte_tx({RSC_TARGET_ADDR, 1'b1}, x);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(1'b1, x);
        stop_c;
    endtask
    // Reset with given straps; bus lines high selects serial mode
    task automatic do_reset(input logic [1:0] s, b, input logic sm);
        sens_sel = s;
        boost_sel = b;
        scl_m = sm;
        sda_low = 1'b0;
        rst_in = 1'b1;
        wt(5);
        rst_in = 1'b0;
        for (int i = 0; i < 50 && done !== 1'b1; i++) wt(1);
        wt(4);
        scl_m = 1'b1;
        wt(10);
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk_sys_in);
        error_cnt++;
        $display("watchdog expired");
        give_verdict;
    end

    // Test sequence
    initial
    begin
        code = '{RSC_SENS_LOW, RSC_SENS_MID, RSC_SENS_HIGH};
        wv = '{RSC_SENS_MAX, 8'h00, 8'ha5};
        for (int i = 0; i < 4; i++)
        begin
            do_reset(2'(i % 3), 2'(i), 1'b1);
            chk("live level", code[i % 3], rx_lvl);
            chk("boost", 8'(i), {6'h0, bst});
            reg_rd(RSC_OFS_RX_SENS, d);
            chk("level reg", code[i % 3], d);
        end
        $display("test straps done");
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(RSC_OFS_RX_SENS, wv[i], k);
            chk("ack", 8'h01, {7'h0, k});
            wt(4);
            chk("written level", wv[i], rx_lvl);
            reg_rd(RSC_OFS_RX_SENS, d);
            chk("read back", wv[i], d);
        end
        reg_wr(8'h26, 8'h77, k);
        reg_rd(8'h26, d);
        chk("unmapped", RSC_UNMAPPED_RD, d);
        reg_rd(RSC_OFS_RX_SENS, d);
        chk("level kept", 8'ha5, d);
        $display("test writes done");
        reg_rd(RSC_OFS_CONFIG, d);
        chk("config reg", 8'h01, d);
        chk("config mode", 8'h01, {7'h0, cfg});
        reg_wr(RSC_OFS_CONFIG, {d[7:1], 1'b0}, k);
        wt(4);
        chk("normal mode", 8'h00, {7'h0, cfg});
        reg_wr(RSC_OFS_CONFIG, d, k);
        wt(4);
        chk("config again", 8'h01, {7'h0, cfg});
        $display("test config done");
        do_reset(2'h2, 2'h1, 1'b0);
        chk("strap back", RSC_SENS_HIGH, rx_lvl);
        chk("no serial", 8'h00, {6'h0, ser, cfg});
        reg_wr(RSC_OFS_RX_SENS, 8'h11, k);
        chk("bus ignored", 8'h00, {7'h0, k});
        wt(4);
        chk("level held", RSC_SENS_HIGH, rx_lvl);
        do_reset(2'h1, 2'h2, 1'b1);
        start_c;
        byte_tx({~RSC_TARGET_ADDR, 1'b0}, k);
        stop_c;
        chk("foreign addr", 8'h00, {7'h0, k});
        $display("test modes done");
        give_verdict;
    end
endmodule

bind rsc_config_top rsc_config_assertions #(.SETTLE_CYC(SETTLE_CYC)) chk_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .sens_above_low_in(sens_above_low_in),
    .sens_above_high_in(sens_above_high_in),
    .boost_thermo_in(boost_thermo_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .rx_sens_level_out(rx_sens_level_out),
    .boost_level_out(boost_level_out), .cfg_mode_out(cfg_mode_out),
    .serial_mode_out(serial_mode_out), .strap_done_out(strap_done_out));
